//--- pkg/accr_pkg.sv
// Package: offsets, reset values and field layouts of the channel registers
package accr_pkg;

  localparam int          ACCR_AW              = 8;
  localparam int          ACCR_DW              = 16;

  localparam logic [7:0]  ACCR_CH5_SETUP_ADDR  = 8'h22;
  localparam logic [7:0]  ACCR_CH5_OFS_HI_ADDR = 8'h23;
  localparam logic [7:0]  ACCR_CH5_OFS_LO_ADDR = 8'h24;
  localparam logic [7:0]  ACCR_CH5_GN_HI_ADDR  = 8'h25;
  localparam logic [7:0]  ACCR_CH5_GN_LO_ADDR  = 8'h26;
  localparam logic [7:0]  ACCR_CH6_SETUP_ADDR  = 8'h27;
  localparam logic [7:0]  ACCR_CH6_OFS_HI_ADDR = 8'h28;

  localparam logic [15:0] ACCR_SETUP_RST       = 16'h0000;
  localparam logic [15:0] ACCR_OFS_HI_RST      = 16'h0000;
  localparam logic [7:0]  ACCR_OFS_LO_RST      = 8'h00;
  localparam logic [15:0] ACCR_GN_HI_RST       = 16'h8000;
  localparam logic [7:0]  ACCR_GN_LO_RST       = 8'h00;
  localparam logic [15:0] ACCR_UNMAPPED_READ   = 16'h0000;

  // Setup word field positions
  localparam int          ACCR_DELAY_MSB       = 15;
  localparam int          ACCR_DELAY_LSB       = 6;
  localparam int          ACCR_DCOFF_BIT       = 2;
  localparam int          ACCR_ROUTE_MSB       = 1;

  typedef enum logic [1:0] {
    ACCR_ROUTE_OWN_PINS = 2'h0,
    ACCR_ROUTE_SHORTED  = 2'h1,
    ACCR_ROUTE_TEST_POS = 2'h2,
    ACCR_ROUTE_TEST_NEG = 2'h3
  } accr_route_t;

  typedef struct packed {
    logic signed [9:0] sample_delay;
    logic              dc_removal_off;
    accr_route_t       input_route;
  } accr_setup_t;

  typedef struct packed {
    logic [ACCR_AW-1:0] addr;
    logic [ACCR_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } accr_bus_req_t;

  typedef struct packed {
    accr_setup_t ch5_setup;
    logic [15:0] ch5_ofs_hi;
    logic [7:0]  ch5_ofs_lo;
    logic [15:0] ch5_gn_hi;
    logic [7:0]  ch5_gn_lo;
    accr_setup_t ch6_setup;
    logic [15:0] ch6_ofs_hi;
    logic [15:0] rdata;
  } accr_state_t;

endpackage : accr_pkg

//--- src/accr_regs.sv
// Channel five and six setup and calibration register bank
// Function
// (R1) Setup bits 15:6 hold signed sample delay
// (R2) Setup bit 2 turns off DC removal
// (R3) Two-bit input route selects pins, short, tests
// (R4) Upper offset word gives offset bits 23:8
// (R5) Lower offset high byte gives bits 7:0
// (R6) Upper gain word gives unsigned gain 23:8
// (R7) Lower gain high byte gives gain 7:0
// (R8) Channel five upper gain at 25h, reset 8000h
// (R9) Channel five upper offset at 23h, zero
// (R10) Channel five lower offset 24h, gain 26h
// (R11) Channel six setup at 27h, reset zero
// (R12) Channel six upper offset at 28h, zero
// (R13) Setup bits 5:3 read as zero
// (R14) Channel five setup at 22h, reset zero
// (R15) Reserved bits ignore writes, read zero
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module accr_regs (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  input  wire logic               global_dc_removal_setting,
  output accr_pkg::accr_setup_t   ch5_setup,
  output accr_pkg::accr_setup_t   ch6_setup,
  output logic                    ch5_dc_removal_on,
  output logic                    ch6_dc_removal_on,
  output logic signed [23:0]      ch5_offset,
  output logic        [23:0]      ch5_gain,
  output logic        [15:0]      ch6_offset_high_bits
);

  accr_pkg::accr_state_t st_r;
  accr_pkg::accr_state_t st_nxt;
  accr_pkg::accr_bus_req_t req;

  // Reserved bits are never stored, so they cannot read back nonzero
  function automatic accr_pkg::accr_setup_t unpack_setup(
    input logic [15:0] w
  );
    accr_pkg::accr_setup_t s;
    s.sample_delay   = w[accr_pkg::ACCR_DELAY_MSB:accr_pkg::ACCR_DELAY_LSB];
    s.dc_removal_off = w[accr_pkg::ACCR_DCOFF_BIT];
    s.input_route    = accr_pkg::accr_route_t'(w[accr_pkg::ACCR_ROUTE_MSB:0]);
    return s;
  endfunction : unpack_setup

  function automatic logic [15:0] pack_setup(
    input accr_pkg::accr_setup_t s
  );
    return {s.sample_delay, 3'h0, s.dc_removal_off, s.input_route}; // R13
  endfunction : pack_setup

  always_comb begin
    req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = accr_pkg::ACCR_UNMAPPED_READ;
    if (req.wr) begin
      if (req.addr == accr_pkg::ACCR_CH5_SETUP_ADDR) begin
        st_nxt.ch5_setup = unpack_setup(req.wdata); // R1 R2 R3 R14 R15
      end else if (req.addr == accr_pkg::ACCR_CH5_OFS_HI_ADDR) begin
        st_nxt.ch5_ofs_hi = req.wdata; // R4 R9
      end else if (req.addr == accr_pkg::ACCR_CH5_OFS_LO_ADDR) begin
        st_nxt.ch5_ofs_lo = req.wdata[15:8]; // R5 R10 R15
      end else if (req.addr == accr_pkg::ACCR_CH5_GN_HI_ADDR) begin
        st_nxt.ch5_gn_hi = req.wdata; // R6 R8
      end else if (req.addr == accr_pkg::ACCR_CH5_GN_LO_ADDR) begin
        st_nxt.ch5_gn_lo = req.wdata[15:8]; // R7 R10 R15
      end else if (req.addr == accr_pkg::ACCR_CH6_SETUP_ADDR) begin
        st_nxt.ch6_setup = unpack_setup(req.wdata); // R11 R15
      end else if (req.addr == accr_pkg::ACCR_CH6_OFS_HI_ADDR) begin
        st_nxt.ch6_ofs_hi = req.wdata; // R12
      end
    end
    if (req.rd) begin
      if (req.addr == accr_pkg::ACCR_CH5_SETUP_ADDR) begin
        st_nxt.rdata = pack_setup(st_r.ch5_setup);
      end else if (req.addr == accr_pkg::ACCR_CH5_OFS_HI_ADDR) begin
        st_nxt.rdata = st_r.ch5_ofs_hi;
      end else if (req.addr == accr_pkg::ACCR_CH5_OFS_LO_ADDR) begin
        st_nxt.rdata = {st_r.ch5_ofs_lo, 8'h00}; // R5 R15
      end else if (req.addr == accr_pkg::ACCR_CH5_GN_HI_ADDR) begin
        st_nxt.rdata = st_r.ch5_gn_hi;
      end else if (req.addr == accr_pkg::ACCR_CH5_GN_LO_ADDR) begin
        st_nxt.rdata = {st_r.ch5_gn_lo, 8'h00}; // R7 R15
      end else if (req.addr == accr_pkg::ACCR_CH6_SETUP_ADDR) begin
        st_nxt.rdata = pack_setup(st_r.ch6_setup);
      end else if (req.addr == accr_pkg::ACCR_CH6_OFS_HI_ADDR) begin
        st_nxt.rdata = st_r.ch6_ofs_hi;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r.ch5_setup  <= unpack_setup(accr_pkg::ACCR_SETUP_RST); // R14
      st_r.ch5_ofs_hi <= accr_pkg::ACCR_OFS_HI_RST; // R9
      st_r.ch5_ofs_lo <= accr_pkg::ACCR_OFS_LO_RST; // R10
      st_r.ch5_gn_hi  <= accr_pkg::ACCR_GN_HI_RST; // R8
      st_r.ch5_gn_lo  <= accr_pkg::ACCR_GN_LO_RST; // R10
      st_r.ch6_setup  <= unpack_setup(accr_pkg::ACCR_SETUP_RST); // R11
      st_r.ch6_ofs_hi <= accr_pkg::ACCR_OFS_HI_RST; // R12
      st_r.rdata      <= accr_pkg::ACCR_UNMAPPED_READ;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata            = st_r.rdata;
  assign ch5_setup            = st_r.ch5_setup;
  assign ch6_setup            = st_r.ch6_setup;
  // Per-channel override only ever turns removal off, never forces it on
  assign ch5_dc_removal_on    = global_dc_removal_setting &
                                ~st_r.ch5_setup.dc_removal_off; // R2
  assign ch6_dc_removal_on    = global_dc_removal_setting &
                                ~st_r.ch6_setup.dc_removal_off; // R2
  assign ch5_offset           = {st_r.ch5_ofs_hi, st_r.ch5_ofs_lo}; // R4 R5
  assign ch5_gain             = {st_r.ch5_gn_hi, st_r.ch5_gn_lo}; // R6 R7
  // Lower half of channel six offset lives outside this bank
  assign ch6_offset_high_bits = st_r.ch6_ofs_hi; // R12

endmodule : accr_regs
`default_nettype wire

//--- verif/accr_regs_checker.sv
// Checker for the channel register bank
`timescale 1ns/100ps
`default_nettype none
module accr_regs_checker (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic [7:0]            reg_addr,
  input wire logic [15:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  global_dc_removal_setting,
  input wire accr_pkg::accr_setup_t ch5_setup,
  input wire accr_pkg::accr_setup_t ch6_setup,
  input wire logic                  ch5_dc_removal_on,
  input wire logic                  ch6_dc_removal_on,
  input wire logic signed [23:0]    ch5_offset,
  input wire logic [23:0]           ch5_gain,
  input wire logic [15:0]           ch6_offset_high_bits
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  idle_rd_a: assert property (!reg_rd || reg_addr > 8'h28 ||
    reg_addr < 8'h22 |=> reg_rdata == 16'h0) else $error("stray data");
  gain_rd_a: assert property (reg_rd && reg_addr == 8'h25 |=>
    reg_rdata == ch5_gain[23:8]) else $error("gain read");
  rsv_rd_a: assert property (reg_rd && reg_addr == 8'h27 |=>
    reg_rdata == {ch6_setup[12:3], 3'h0, ch6_setup[2:0]}) else $error("rsv");
  ofs_hi_a: assert property (reg_wr && reg_addr == 8'h23 |=>
    ch5_offset[23:8] == $past(reg_wdata)) else $error("offset high");
  ofs_lo_a: assert property (reg_wr && reg_addr == 8'h24 |=>
    ch5_offset[7:0] == $past(reg_wdata[15:8])) else $error("offset low");
  gain_lo_a: assert property (reg_wr && reg_addr == 8'h26 |=>
    ch5_gain[7:0] == $past(reg_wdata[15:8])) else $error("gain low");
  delay_wr_a: assert property (reg_wr && reg_addr == 8'h27 |=>
    ch6_setup[12:3] == $past(reg_wdata[15:6])) else $error("delay");
  rst_val_a: assert property ($fell(rst) |->
    ch5_gain == 24'h800000 && ch5_offset == 24'h0) else $error("reset");
  rst_cfg_a: assert property ($fell(rst) |->
    {ch5_setup, ch6_setup, ch6_offset_high_bits} == 42'h0)
    else $error("reset setup");
  dc_follow_a: assert property (ch5_dc_removal_on ==
    (global_dc_removal_setting && !ch5_setup[2]) && ch6_dc_removal_on ==
    (global_dc_removal_setting && !ch6_setup[2])) else $error("dc removal");
  setup5_wr_a: assert property (reg_wr && reg_addr == 8'h22 |=>
    ch5_setup == {$past(reg_wdata[15:6]), $past(reg_wdata[2:0])})
    else $error("ch5 setup");
  ofs6_wr_a: assert property (reg_wr && reg_addr == 8'h28 |=>
    ch6_offset_high_bits == $past(reg_wdata)) else $error("ch6 offset");
endmodule : accr_regs_checker
bind accr_regs accr_regs_checker u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .global_dc_removal_setting, .ch5_setup,
  .ch6_setup, .ch5_dc_removal_on, .ch6_dc_removal_on, .ch5_offset,
  .ch5_gain, .ch6_offset_high_bits);
`default_nettype wire

//--- verif/tb.sv
// Bench for the channel register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("unexpected %0t value %h", $time, a); end end
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, global_dc_removal_setting = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ch5_dc_removal_on;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic signed [23:0] ch5_offset;
  logic [23:0] ch5_gain;
  logic ch6_dc_removal_on;
  logic [15:0] ch6_offset_high_bits;
  accr_pkg::accr_setup_t ch5_setup, ch6_setup;
  int failures = 0, compares = 0;
  accr_regs dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .global_dc_removal_setting, .ch5_setup, .ch6_setup,
    .ch5_dc_removal_on, .ch6_dc_removal_on, .ch5_offset, .ch5_gain,
    .ch6_offset_high_bits);
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge clk_sys) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys) {reg_wr, reg_rd} <= 2'b00;
    #1 if (!w) `CHK(reg_rdata, d)
  endtask : bus
  task automatic reset_and_setup();
    for (int i = 0; i < 8; i++)
      bus(0, 8'h22 + 8'(i), (i == 3) ? 16'h8000 : 16'h0000);
    bus(1, 8'h22, 16'hffff);
    bus(0, 8'h22, 16'hffc7);
    `CHK(ch5_dc_removal_on, 1'b0)
    for (int r = 0; r < 4; r++) begin
      bus(1, 8'h27, 16'h8038 | 16'(r));
      bus(0, 8'h27, 16'h8000 | 16'(r));
    end
  endtask : reset_and_setup
  task automatic cal_words();
    bus(1, 8'h23, 16'h8001);
    bus(1, 8'h24, 16'hffff);
    bus(1, 8'h25, 16'hfffe);
    bus(1, 8'h26, 16'h12ff);
    bus(0, 8'h24, 16'hff00);
    `CHK({ch5_offset, ch5_gain}, 48'h8001ff_fffe12)
  endtask : cal_words
  task automatic fields_and_dc();
    `CHK(ch6_setup, 13'h1003)
    bus(1, 8'h22, 16'h807e);
    `CHK(ch5_setup, 13'h100e)
    `CHK(ch5_setup.sample_delay, -10'sd511)
    `CHK({ch5_dc_removal_on, ch6_dc_removal_on}, 2'h1)
    bus(1, 8'h22, 16'h0001);
    `CHK({ch5_setup, ch5_dc_removal_on}, 14'h0003)
    @(posedge clk_sys) global_dc_removal_setting <= 1'h0;
    #1 `CHK({ch5_dc_removal_on, ch6_dc_removal_on}, 2'h0)
    @(posedge clk_sys) global_dc_removal_setting <= 1'h1;
    bus(1, 8'h28, 16'ha5c3);
    `CHK(ch6_offset_high_bits, 16'ha5c3)
    bus(0, 8'h28, 16'ha5c3);
  endtask : fields_and_dc
  task automatic reset_midrun();
    @(posedge clk_sys) rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    #1 `CHK({ch5_offset, ch5_gain}, 48'h000000_800000)
    `CHK({ch5_setup, ch6_setup, ch6_offset_high_bits}, 42'h0)
    bus(0, 8'h23, 16'h0000);
    bus(0, 8'h25, 16'h8000);
    bus(0, 8'h26, 16'h0000);
  endtask : reset_midrun
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    reset_and_setup();
    cal_words();
    fields_and_dc();
    reset_midrun();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
